// ### logic/eil_pkg.sv
// package: register map, field layout, reset values and carriers of the ext/status latch
package eil_pkg;
    // ************************************************************
    // register offsets (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_IMODE = 8'h04;
    localparam logic [7:0] OFS_SRCEN = 8'h08;
    localparam logic [7:0] OFS_XOPT = 8'h0C;
    localparam logic [7:0] OFS_MODE = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_TXDATA = 8'h18;
    // ************************************************************
    // status / source-enable bit positions
    // ************************************************************
    localparam int BIT_PEND = 0;
    localparam int BIT_ZC = 1;
    localparam int BIT_TBE = 2;
    localparam int BIT_DCD = 3;
    localparam int BIT_SYNC = 4;
    localparam int BIT_CTS = 5;
    localparam int BIT_EOM = 6;
    localparam int BIT_BRK = 7;
    localparam logic [7:0] MASK_BOTH_EDGE = 8'hB8;
    localparam logic [7:0] MASK_RISE_EDGE = 8'h42;
    localparam logic [7:0] MASK_PIN_SRC = 8'h28;
    localparam logic [7:0] MASK_LATCHABLE = 8'hF8;
    // ************************************************************
    // command and option fields
    // ************************************************************
    localparam int CMD_LSB = 3;
    localparam logic [2:0] CMD_RST_EXT = 3'h2;
    localparam logic [2:0] CMD_SEND_ABORT = 3'h3;
    localparam logic [2:0] CMD_ENTER_HUNT = 3'h4;
    localparam logic [2:0] CMD_RST_EOM = 3'h5;
    localparam int IMODE_MIE_BIT = 0;
    localparam int XOPT_AUTOFLAG_BIT = 0;
    localparam int XOPT_ENH_BIT = 1;
    localparam int MODE_XTAL_BIT = 2;
    // ************************************************************
    // reset values and counts
    // ************************************************************
    localparam logic [7:0] RST_IMODE = 8'h00;
    localparam logic [7:0] RST_SRCEN = 8'h00;
    localparam logic [7:0] RST_XOPT = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [2:0] ABORT_ONES = 3'h7;

    typedef enum logic [1:0] {EIL_ASYNC, EIL_SYNC, EIL_SDLC, EIL_EXTSYNC} eil_mode_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } eil_wb_req_t;

    typedef struct packed {
        logic cts;
        logic dcd;
        logic sync;
        logic rx_valid;
        logic rx_bit;
        logic rx_null_fe;
    } eil_line_t;

    typedef struct packed {
        logic crc_load;
        logic crc_done;
        logic tx_load;
        logic char_sync;
        logic brg_zero;
        logic brg_reload;
    } eil_evt_t;
endpackage

// ### logic/eil_brk_detect.sv
// break / abort detector on the received bit stream
`timescale 1ns/1ps
module eil_brk_detect
    import eil_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic sys_rst, // async reset, active high
    input wire eil_mode_t mode, // channel mode
    input wire logic rx_valid, // one received bit present
    input wire logic rx_bit, // received bit value
    input wire logic rx_null_fe, // null char with framing error
    output logic brk_q, // break/abort status
    output logic null_push_q // leave one null in rx fifo
);
    logic [2:0] ones_q, ones_d;
    logic brk_d;
    logic null_push_d;

    always_comb begin
        ones_d = ones_q;
        brk_d = brk_q;
        null_push_d = 1'b0;
        unique case (mode)
            EIL_ASYNC: begin
                if (rx_null_fe) begin
                    brk_d = 1'b1;
                end else if (rx_valid && rx_bit && brk_q) begin
                    brk_d = 1'b0;
                    null_push_d = 1'b1;
                end
            end
            EIL_SDLC: begin
                if (rx_valid && rx_bit) begin
                    if (ones_q != ABORT_ONES) begin
                        ones_d = ones_q + 3'h1;
                    end
                    if (ones_q == ABORT_ONES - 3'h1 || ones_q == ABORT_ONES) begin
                        brk_d = 1'b1;
                    end
                end else if (rx_valid) begin
                    ones_d = 3'h0;
                    brk_d = 1'b0;
                end
            end
            EIL_SYNC, EIL_EXTSYNC: begin
                ones_d = 3'h0;
                brk_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ones_q <= 3'h0;
            brk_q <= 1'b0;
            null_push_q <= 1'b0;
        end else begin
            ones_q <= ones_d;
            brk_q <= brk_d;
            null_push_q <= null_push_d;
        end
    end

    chk_abort_seven_ones: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (mode == EIL_SDLC && rx_valid && rx_bit && ones_q == 3'h6) |=> brk_q)
        else $error("abort not flagged after seven ones");
    chk_break_quiet_sync: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (mode == EIL_SYNC) |=> !brk_q)
        else $error("break status set in plain sync mode");
endmodule

// ### logic/eil_ext_status_latch.sv
// ext/status interrupt latch of one serial channel, wishbone register slave
`timescale 1ns/1ps
// Contract
// - six sources gated by master enable and per-source enable bits
// - enable 0 shows live status, enable 1 shows latched status, except zero count which stays live
// - all latches close together on any enabled source change except a fall of eom or zero count
// - pending flag set while latches are closed
// - master enable clear keeps pending clear, latches still work
// - reset-ext/status command opens the latches
// - enhanced variant holds status stable during a read
// - basic variant captures status at read start, updates after
// - break reads 0 in non-sdlc sync; async set on null+fe, clear on one
// - end of break leaves one null character in the receive fifo
// - sdlc abort on seven ones, cleared by a zero, forces hunt
// - both break edges close latches even when already pending
// - underrun/eom clears only by command; clearing never closes latches
// - underrun/eom sets on crc load or send abort; always set async
// - enhanced sdlc eom may signal next-frame write with auto flag
// - cts and dcd mirror pins; either edge closes latches
// - after reset command, odd pin transitions keep latches closed
// - zero count sets at zero, clears on reload, always live
// - zero count forced 0 while its enable is clear
// - async/ext-sync sync follows pin; xtal in async forces 0
// - basic variant: data written during crc replaces the crc
// - enhanced variant: crc wins, tx buffer empty stays clear
// - sync modes: hunt set by command, cleared on character sync
module eil_ext_status_latch
    import eil_pkg::*;
(
    input wire logic sys_clk, // system clock, 100 MHz
    input wire logic sys_rst, // async reset, active high
    input wire eil_pkg::eil_wb_req_t wb_req, // wishbone request group
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    input wire eil_pkg::eil_line_t line_in, // modem pins and receive stream
    input wire eil_pkg::eil_evt_t evt_in, // transmitter / baud generator events
    output logic ext_status_pending, // ext/status interrupt pending
    output logic rx_hunt, // receiver hunt request
    output logic rx_push_null, // push one null char into rx fifo
    output logic [7:0] tx_data, // byte waiting for the shift register
    output logic tx_full, // transmit buffer holds a byte
    output logic tx_crc_abort // replace pending crc with flag/sync
);
    import eil_pkg::*;

    // ************************************************************
    // register bus
    // ************************************************************
    logic [7:0] imode_q, imode_d;
    logic [7:0] srcen_q, srcen_d;
    logic [7:0] xopt_q, xopt_d;
    logic [7:0] mode_q, mode_d;
    logic [31:0] dat_q, dat_d;
    logic ack_q, ack_d;
    logic acc, wr_acc;
    logic cmd_rst_ext, cmd_send_abort, cmd_enter_hunt, cmd_rst_eom, wr_tx;
    logic [7:0] view;
    eil_mode_t mode;
    logic enh, mie;

    assign acc = wb_req.cyc && wb_req.stb && !ack_q;
    // writes land at the edge where ack is seen high, while the master still holds the request
    assign wr_acc = wb_req.cyc && wb_req.stb && ack_q && wb_req.we && wb_req.sel[0];
    assign cmd_rst_ext = wr_acc && wb_req.adr == OFS_CMD
        && wb_req.dat[CMD_LSB +: 3] == CMD_RST_EXT;
    assign cmd_send_abort = wr_acc && wb_req.adr == OFS_CMD
        && wb_req.dat[CMD_LSB +: 3] == CMD_SEND_ABORT;
    assign cmd_enter_hunt = wr_acc && wb_req.adr == OFS_CMD
        && wb_req.dat[CMD_LSB +: 3] == CMD_ENTER_HUNT;
    assign cmd_rst_eom = wr_acc && wb_req.adr == OFS_CMD
        && wb_req.dat[CMD_LSB +: 3] == CMD_RST_EOM;
    assign wr_tx = wr_acc && wb_req.adr == OFS_TXDATA;
    assign mode = eil_mode_t'(mode_q[1:0]);
    assign enh = xopt_q[XOPT_ENH_BIT];
    assign mie = imode_q[IMODE_MIE_BIT];

    always_comb begin
        imode_d = imode_q;
        srcen_d = srcen_q;
        xopt_d = xopt_q;
        mode_d = mode_q;
        dat_d = dat_q;
        ack_d = acc;
        if (wr_acc) begin
            unique case (wb_req.adr)
                OFS_IMODE: imode_d = wb_req.dat[7:0];
                OFS_SRCEN: srcen_d = wb_req.dat[7:0];
                OFS_XOPT: xopt_d = wb_req.dat[7:0];
                OFS_MODE: mode_d = wb_req.dat[7:0];
                default: ;
            endcase
        end
        if (acc && !wb_req.we) begin
            // snapshot taken once per access so a late closure cannot tear the word
            unique case (wb_req.adr)
                OFS_IMODE: dat_d = {24'h0, imode_q};
                OFS_SRCEN: dat_d = {24'h0, srcen_q};
                OFS_XOPT: dat_d = {24'h0, xopt_q};
                OFS_MODE: dat_d = {24'h0, mode_q};
                OFS_STATUS: dat_d = {24'h0, view};
                default: dat_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            imode_q <= RST_IMODE;
            srcen_q <= RST_SRCEN;
            xopt_q <= RST_XOPT;
            mode_q <= RST_MODE;
            dat_q <= 32'h0;
            ack_q <= 1'b0;
        end else begin
            imode_q <= imode_d;
            srcen_q <= srcen_d;
            xopt_q <= xopt_d;
            mode_q <= mode_d;
            dat_q <= dat_d;
            ack_q <= ack_d;
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;

    // ************************************************************
    // live status sources
    // ************************************************************
    logic brk_st, null_push;
    logic eom_q, eom_d;
    logic hunt_q, hunt_d;
    logic zc_q, zc_d;
    logic brk_prev_q;
    logic [7:0] live;

    eil_brk_detect u_brk (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .mode(mode),
        .rx_valid(line_in.rx_valid),
        .rx_bit(line_in.rx_bit),
        .rx_null_fe(line_in.rx_null_fe),
        .brk_q(brk_st),
        .null_push_q(null_push)
    );

    always_comb begin
        eom_d = eom_q;
        hunt_d = hunt_q;
        zc_d = zc_q;
        if (cmd_rst_eom) begin
            eom_d = 1'b0;
        end
        // crc load also tells enhanced sdlc software the next frame may be written
        if (evt_in.crc_load || cmd_send_abort) begin
            eom_d = 1'b1;
        end
        if (evt_in.char_sync && mode != EIL_SDLC) begin
            hunt_d = 1'b0;
        end
        if (evt_in.char_sync && mode == EIL_SDLC) begin
            hunt_d = 1'b0;
        end
        if (cmd_enter_hunt || (mode == EIL_SDLC && brk_st && !brk_prev_q)) begin
            hunt_d = 1'b1;
        end
        if (evt_in.brg_reload) begin
            zc_d = 1'b0;
        end
        if (evt_in.brg_zero) begin
            zc_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            eom_q <= 1'b0;
            hunt_q <= 1'b1;
            zc_q <= 1'b0;
            brk_prev_q <= 1'b0;
        end else begin
            eom_q <= eom_d;
            hunt_q <= hunt_d;
            zc_q <= zc_d;
            brk_prev_q <= brk_st;
        end
    end

    always_comb begin
        live = 8'h00;
        live[BIT_BRK] = brk_st;
        live[BIT_EOM] = (mode == EIL_ASYNC) ? 1'b1 : eom_q;
        live[BIT_CTS] = line_in.cts;
        live[BIT_DCD] = line_in.dcd;
        live[BIT_ZC] = zc_q && srcen_q[BIT_ZC];
        unique case (mode)
            EIL_ASYNC: live[BIT_SYNC] = line_in.sync && !mode_q[MODE_XTAL_BIT];
            EIL_EXTSYNC: live[BIT_SYNC] = line_in.sync;
            EIL_SYNC, EIL_SDLC: live[BIT_SYNC] = hunt_q;
        endcase
    end

    // ************************************************************
    // shared latch and pending flag
    // ************************************************************
    logic [7:0] lat_q, lat_d;
    logic [7:0] prev_q;
    logic closed_q, closed_d;
    logic pend_q, pend_d;
    logic [7:0] chg;
    logic trig_any, brk_edge, pin_odd;
    logic tx_full_q, tx_full_d;

    assign chg = live ^ prev_q;
    assign trig_any = |(chg & srcen_q & MASK_BOTH_EDGE)
        || |(live & ~prev_q & srcen_q & MASK_RISE_EDGE);
    assign brk_edge = chg[BIT_BRK] && srcen_q[BIT_BRK];
    // parity of pin transitions equals inequality of pin and latched copy
    assign pin_odd = |((live ^ lat_q) & srcen_q & MASK_PIN_SRC);

    always_comb begin
        closed_d = closed_q;
        lat_d = lat_q;
        if (cmd_rst_ext && closed_q) begin
            closed_d = 1'b0;
            if (pin_odd) begin
                closed_d = 1'b1;
                lat_d = live;
            end
        end
        // only a break edge in the cycle of the reset command wins over the reopen
        if ((!closed_q && trig_any) || brk_edge) begin
            closed_d = 1'b1;
            lat_d = live;
        end
        pend_d = closed_d && mie;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lat_q <= 8'h00;
            prev_q <= 8'h00;
            closed_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            lat_q <= lat_d;
            prev_q <= live;
            closed_q <= closed_d;
            pend_q <= pend_d;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_view
            if (gi == BIT_PEND) begin : g_pend
                assign view[gi] = pend_q;
            end else if (gi == BIT_TBE) begin : g_tbe
                assign view[gi] = !tx_full_q;
            end else if (MASK_LATCHABLE[gi]) begin : g_lat
                assign view[gi] = (srcen_q[gi] && closed_q) ? lat_q[gi] : live[gi];
            end else begin : g_live
                assign view[gi] = live[gi];
            end
        end
    endgenerate

    // ************************************************************
    // transmit data versus crc priority
    // ************************************************************
    logic crc_phase_q, crc_phase_d;
    logic [7:0] tx_data_q, tx_data_d;
    logic crc_abort_q, crc_abort_d;
    logic hunt_out_q, null_out_q;

    always_comb begin
        crc_phase_d = crc_phase_q;
        tx_full_d = tx_full_q;
        tx_data_d = tx_data_q;
        crc_abort_d = 1'b0;
        if (evt_in.crc_done) begin
            crc_phase_d = 1'b0;
        end
        if (evt_in.crc_load) begin
            crc_phase_d = 1'b1;
        end
        if (evt_in.tx_load) begin
            tx_full_d = 1'b0;
        end
        if (wr_tx) begin
            tx_full_d = 1'b1;
            tx_data_d = wb_req.dat[7:0];
            if (crc_phase_q && !enh) begin
                crc_abort_d = 1'b1;
                crc_phase_d = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            crc_phase_q <= 1'b0;
            tx_full_q <= 1'b0;
            tx_data_q <= 8'h00;
            crc_abort_q <= 1'b0;
            hunt_out_q <= 1'b1;
            null_out_q <= 1'b0;
        end else begin
            crc_phase_q <= crc_phase_d;
            tx_full_q <= tx_full_d;
            tx_data_q <= tx_data_d;
            crc_abort_q <= crc_abort_d;
            hunt_out_q <= hunt_d;
            null_out_q <= null_push;
        end
    end

    assign ext_status_pending = pend_q;
    assign rx_hunt = hunt_out_q;
    assign rx_push_null = null_out_q;
    assign tx_data = tx_data_q;
    assign tx_full = tx_full_q;
    assign tx_crc_abort = crc_abort_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    chk_pend_needs_mie: assert property (pend_q |-> $past(mie))
        else $error("pending set with master enable clear");
    chk_pend_means_closed: assert property (pend_q |-> closed_q)
        else $error("pending without closed latches");
    chk_close_on_change: assert property ((!closed_q && trig_any) |=> closed_q && pend_q == $past(mie))
        else $error("latches did not close on enabled change");
    chk_brk_recapture: assert property (brk_edge |=> closed_q && lat_q[BIT_BRK] == $past(live[BIT_BRK]))
        else $error("break edge not captured");
    chk_reset_opens: assert property ((cmd_rst_ext && closed_q && !pin_odd && !trig_any && !brk_edge)
        |=> !closed_q && !pend_q)
        else $error("reset command did not open latches");
    chk_odd_stays_closed: assert property ((cmd_rst_ext && closed_q && pin_odd) |=> closed_q)
        else $error("odd pin transitions reopened latches");
    chk_open_noop_reset: assert property ((cmd_rst_ext && !closed_q && !trig_any && !brk_edge)
        |=> !closed_q)
        else $error("reset command with open latches closed them");
    chk_eom_async_set: assert property ((mode == EIL_ASYNC) |-> live[BIT_EOM])
        else $error("underrun/eom clear in async mode");
    chk_eom_fall_quiet: assert property ((!closed_q && $fell(eom_q) && mode != EIL_ASYNC
        && (chg & srcen_q & 8'hBA) == 8'h00) |-> !closed_d)
        else $error("eom clearing closed the latches");
    chk_zc_forced_low: assert property (!srcen_q[BIT_ZC] |-> !view[BIT_ZC])
        else $error("zero count visible while disabled");
    chk_unlatched_live: assert property (!srcen_q[BIT_CTS] |-> view[BIT_CTS] == line_in.cts)
        else $error("disabled source not shown live");
    chk_xtal_sync_low: assert property ((mode == EIL_ASYNC && mode_q[MODE_XTAL_BIT]) |-> !live[BIT_SYNC])
        else $error("sync not forced low with crystal");
    chk_basic_crc_drop: assert property ((wr_tx && crc_phase_q && !enh) |=> tx_crc_abort ##1 !tx_crc_abort)
        else $error("basic variant kept crc over data");
    chk_abort_hunt: assert property ((mode == EIL_SDLC && $rose(brk_st)) |=> hunt_q)
        else $error("abort did not force hunt");

    cov_pending_raised: cover property ($rose(pend_q));
    cov_reset_reopen: cover property (cmd_rst_ext && closed_q ##1 !closed_q);
    cov_odd_keep: cover property (cmd_rst_ext && closed_q && pin_odd);
    cov_enh_crc_hold: cover property (wr_tx && crc_phase_q && enh);
endmodule

// ### dv/eil_line_model.sv
// line side partner: modem pins, receive stream and transmitter/baud events
`timescale 1ns/1ps
module eil_line_model
    import eil_pkg::*;
(
    input wire logic sys_clk, // system clock
    output eil_pkg::eil_line_t line_o, // pins and receive stream
    output eil_pkg::eil_evt_t evt_o // one-cycle event pulses
);
    import eil_pkg::*;
    logic [5:0] pin_q = 6'h00;
    logic [5:0] ev_q = 6'h00;
    assign line_o = pin_q;
    assign evt_o = ev_q;
    // pins move only after an edge, like a synchronised input
    task automatic set_pin(input int k, input logic v);
        @(posedge sys_clk);
        pin_q[k] <= v;
    endtask
    // event and receive-stream pin pulses last exactly one cycle, then those strobes return idle; pins 5..3 stay set
    task automatic pulse(input int k, input logic evt);
        @(posedge sys_clk);
        if (evt) ev_q[k] <= 1'b1; else pin_q[k] <= 1'b1;
        @(posedge sys_clk);
        ev_q <= 6'h00;
        pin_q[2:0] <= 3'h0;
    endtask
endmodule

// ### dv/tb_top.sv
// register-level testbench of the ext/status latch
`timescale 1ns/1ps
module tb_top;
    import eil_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    eil_wb_req_t req = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, pend, hunt;
    eil_line_t line;
    eil_evt_t evt;
    int errors = 0;
    int n_compared = 0;
    logic [31:0] r;
    logic nul, cab, txf;
    logic [7:0] txd;
    int n_null = 0;
    int n_abort = 0;
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    eil_line_model u_line (.sys_clk(sys_clk), .line_o(line), .evt_o(evt));
    eil_ext_status_latch DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_req(req), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .line_in(line), .evt_in(evt), .ext_status_pending(pend), .rx_hunt(hunt),
        .rx_push_null(nul), .tx_data(txd), .tx_full(txf), .tx_crc_abort(cab));
    // one-cycle pulses are counted so later checks need not catch them live
    always @(posedge sys_clk) begin
        if (nul === 1'b1) n_null <= n_null + 1;
        if (cab === 1'b1) n_abort <= n_abort + 1;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // ack is sampled before the edge's own updates land
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h0, d}};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        r = wb_dat_o;
        req <= '0;
        if (n >= 50) chk("ack", 8'h01, 8'h00);
    endtask
    task automatic cmd(input logic [2:0] c);
        wb(1'b1, OFS_CMD, {2'h0, c, 3'h0});
    endtask
    task automatic st(input int b, input logic e, input string nm);
        repeat (3) @(posedge sys_clk);
        wb(1'b0, OFS_STATUS, 8'h00);
        chk(nm, {7'h0, e}, {7'h0, r[b]});
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        end_sim;
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        chk("pend_rst", 8'h00, {7'h0, pend});
        chk("hunt_rst", 8'h01, {7'h0, hunt});
        wb(1'b1, OFS_IMODE, 8'h01);
        wb(1'b1, OFS_SRCEN, 8'h20);
        u_line.set_pin(5, 1'b1);
        st(BIT_PEND, 1'b1, "pend_cts");
        u_line.set_pin(5, 1'b0);
        st(BIT_CTS, 1'b1, "cts_latched");
        cmd(CMD_RST_EXT);
        st(BIT_PEND, 1'b1, "pend_odd");
        st(BIT_CTS, 1'b0, "cts_relatch");
        u_line.set_pin(5, 1'b1);
        u_line.set_pin(5, 1'b0);
        cmd(CMD_RST_EXT);
        st(BIT_PEND, 1'b0, "pend_even");
        cmd(CMD_RST_EXT);
        cmd(CMD_RST_EXT);
        st(BIT_PEND, 1'b0, "pend_open");
        $display("test cts done");
        wb(1'b1, OFS_IMODE, 8'h00);
        u_line.set_pin(5, 1'b1);
        st(BIT_PEND, 1'b0, "pend_nomie");
        u_line.set_pin(5, 1'b0);
        st(BIT_CTS, 1'b1, "latch_nomie");
        // one odd transition re-closes, the second command reopens
        cmd(CMD_RST_EXT);
        cmd(CMD_RST_EXT);
        wb(1'b1, OFS_IMODE, 8'h01);
        wb(1'b1, OFS_SRCEN, 8'h00);
        st(BIT_CTS, 1'b0, "cts_live");
        $display("test master enable done");
        u_line.pulse(1, 1'b1);
        st(BIT_ZC, 1'b0, "zc_off");
        // reload first so that enabling the source sees no edge
        u_line.pulse(0, 1'b1);
        wb(1'b1, OFS_SRCEN, 8'h02);
        u_line.pulse(1, 1'b1);
        st(BIT_ZC, 1'b1, "zc_set");
        chk("pend_zc", 8'h01, {7'h0, pend});
        u_line.pulse(0, 1'b1);
        st(BIT_ZC, 1'b0, "zc_reload");
        cmd(CMD_RST_EXT);
        $display("test zero count done");
        wb(1'b1, OFS_MODE, 8'h01);
        wb(1'b1, OFS_SRCEN, 8'h40);
        cmd(CMD_RST_EOM);
        cmd(CMD_RST_EXT);
        cmd(CMD_SEND_ABORT);
        st(BIT_EOM, 1'b1, "eom_abort");
        chk("pend_eom", 8'h01, {7'h0, pend});
        cmd(CMD_RST_EXT);
        cmd(CMD_RST_EOM);
        st(BIT_PEND, 1'b0, "pend_eomclr");
        st(BIT_EOM, 1'b0, "eom_clr");
        u_line.pulse(5, 1'b1);
        st(BIT_EOM, 1'b1, "eom_crc");
        cmd(CMD_RST_EXT);
        u_line.pulse(0, 1'b0);
        st(BIT_BRK, 1'b0, "brk_sync");
        wb(1'b1, OFS_SRCEN, 8'h00);
        wb(1'b1, OFS_MODE, 8'h00);
        st(BIT_EOM, 1'b1, "eom_async");
        $display("test eom done");
        wb(1'b1, OFS_SRCEN, 8'h80);
        u_line.pulse(0, 1'b0);
        st(BIT_BRK, 1'b1, "brk_set");
        chk("pend_brk", 8'h01, {7'h0, pend});
        u_line.set_pin(1, 1'b1);
        u_line.pulse(2, 1'b0);
        st(BIT_BRK, 1'b0, "brk_relatch");
        chk("null_push", 8'h01, n_null[7:0]);
        cmd(CMD_RST_EXT);
        $display("test break done");
        wb(1'b1, OFS_MODE, 8'h01);
        u_line.pulse(2, 1'b1);
        wb(1'b1, OFS_SRCEN, 8'h10);
        cmd(CMD_ENTER_HUNT);
        st(BIT_PEND, 1'b1, "pend_hunt");
        chk("hunt_set", 8'h01, {7'h0, hunt});
        cmd(CMD_RST_EXT);
        u_line.pulse(2, 1'b1);
        st(BIT_PEND, 1'b1, "pend_sync");
        chk("hunt_clr", 8'h00, {7'h0, hunt});
        cmd(CMD_RST_EXT);
        wb(1'b1, OFS_SRCEN, 8'h00);
        wb(1'b1, OFS_MODE, 8'h02);
        repeat (7) begin
            u_line.set_pin(1, 1'b1);
            u_line.pulse(2, 1'b0);
        end
        st(BIT_BRK, 1'b1, "abort_set");
        chk("hunt_abort", 8'h01, {7'h0, hunt});
        u_line.pulse(2, 1'b0);
        st(BIT_BRK, 1'b0, "abort_clr");
        $display("test hunt done");
        u_line.pulse(5, 1'b1);
        wb(1'b1, OFS_TXDATA, 8'h5A);
        st(BIT_TBE, 1'b0, "tbe_full");
        chk("tx_data", 8'h5A, txd);
        chk("crc_abort", 8'h01, n_abort[7:0]);
        u_line.pulse(3, 1'b1);
        u_line.pulse(4, 1'b1);
        wb(1'b1, OFS_XOPT, 8'h03);
        u_line.pulse(5, 1'b1);
        wb(1'b1, OFS_TXDATA, 8'hA5);
        st(BIT_TBE, 1'b0, "tbe_enh");
        chk("crc_kept", 8'h01, n_abort[7:0]);
        chk("tx_full", 8'h01, {7'h0, txf});
        $display("test tx done");
        wb(1'b1, OFS_MODE, 8'h04);
        u_line.set_pin(3, 1'b1);
        st(BIT_SYNC, 1'b0, "sync_xtal");
        wb(1'b1, OFS_MODE, 8'h03);
        st(BIT_SYNC, 1'b1, "sync_pin");
        $display("test sync pin done");
        wb(1'b0, 8'h1C, 8'h00);
        chk("unmapped", 8'h00, r[7:0]);
        $display("test bus done");
        end_sim;
    end
endmodule
